// [ltx_pkg.sv]
// package: constants and types for the lin transceiver host interface
package ltx_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int WAKE_DOM_US = 150;
  localparam int WAKE_CYC = (WAKE_DOM_US * (CLK_HZ / 1000000)) + 1;
  localparam logic [11:0] WAKE_CNT_MAX = 12'(WAKE_CYC);
  localparam logic [11:0] WAKE_CNT_RST = 12'h000;
  localparam logic TX_EN_RST = 1'b0;
  localparam logic PULLUP_RST = 1'b1;
  typedef enum logic [1:0] {LTX_SLEEP, LTX_STANDBY, LTX_NORMAL} ltx_mode_t;
endpackage

// [ltx_sync.sv]
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module ltx_sync (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = d_in;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign q_out = sync_q;
endmodule

// [ltx_top.sv]
// lin transceiver host-side digital logic
`timescale 1ns/1ps
module ltx_top (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic TX_IN,
  input wire logic BUS_IN,
  output logic BUS_OUT,
  output logic BUS_OE_OUT,
  output logic RX_OUT,
  output logic RX_OE_OUT,
  input wire logic FAULT_OR_TX_ENABLE_PIN_IN,
  output logic FAULT_OR_TX_ENABLE_PIN_OUT,
  output logic FAULT_OR_TX_ENABLE_PIN_OE_OUT,
  output logic FAULT_OR_TX_ENABLE_PIN_WEAK_OUT,
  input wire logic BUS_FAULT_IN,
  input wire logic CHIP_ENABLE_IN,
  input wire logic SLEEP_REQ_IN,
  input wire logic BUS_PULLUP_ENABLE_IN,
  output logic BUS_PULLUP_OUT,
  output ltx_pkg::ltx_mode_t MODE_OUT,
  output logic WAKE_OUT
);
  import ltx_pkg::*;
  logic tx_s;
  logic bus_s;
  logic fen_s;
  logic fault_s;
  logic ce_s;
  ltx_sync u_tx (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .d_in(TX_IN), .q_out(tx_s));
  ltx_sync u_bus (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .d_in(BUS_IN), .q_out(bus_s));
  ltx_sync u_fen (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN),
    .d_in(FAULT_OR_TX_ENABLE_PIN_IN), .q_out(fen_s));
  ltx_sync u_flt (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .d_in(~BUS_FAULT_IN), .q_out(fault_s));
  ltx_sync u_ce (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .d_in(CHIP_ENABLE_IN), .q_out(ce_s));
  logic fault;
  assign fault = ~fault_s;
  ltx_mode_t mode_q;
  ltx_mode_t mode_d;
  logic [11:0] dom_q;
  logic [11:0] dom_d;
  logic armed_q;
  logic armed_d;
  logic bus_prev_q;
  logic bus_prev_d;
  logic wake_q;
  logic wake_d;
  logic tx_en_q;
  logic tx_en_d;
  logic fen_prev_q;
  logic fen_prev_d;
  logic pu_q;
  logic pu_d;
  logic rx_q;
  logic rx_d;
  logic bus_drv_q;
  logic bus_drv_d;
  always_comb begin
    mode_d = mode_q;
    dom_d = dom_q;
    armed_d = armed_q;
    bus_prev_d = bus_s;
    wake_d = 1'b0;
    pu_d = pu_q;
    case (mode_q)
      LTX_SLEEP: begin
        if (!bus_s) begin
          if (dom_q != WAKE_CNT_MAX) begin
            dom_d = dom_q + 12'h001;
          end else begin
            armed_d = 1'b1;
          end
        end else begin
          dom_d = WAKE_CNT_RST;
          if (armed_q && !bus_prev_q) begin
            wake_d = 1'b1;
            armed_d = 1'b0;
            mode_d = LTX_STANDBY;
          end
        end
      end
      LTX_STANDBY: begin
        dom_d = WAKE_CNT_RST;
        armed_d = 1'b0;
        pu_d = BUS_PULLUP_ENABLE_IN;
        if (ce_s) begin
          mode_d = LTX_NORMAL;
        end else if (SLEEP_REQ_IN) begin
          mode_d = LTX_SLEEP;
        end
      end
      LTX_NORMAL: begin
        if (!ce_s) begin
          mode_d = LTX_STANDBY;
        end
      end
      default: begin
        mode_d = LTX_STANDBY;
      end
    endcase
  end
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mode_q <= LTX_STANDBY;
      dom_q <= WAKE_CNT_RST;
      armed_q <= 1'b0;
      bus_prev_q <= 1'b1;
      wake_q <= 1'b0;
      pu_q <= PULLUP_RST;
    end else begin
      mode_q <= mode_d;
      dom_q <= dom_d;
      armed_q <= armed_d;
      bus_prev_q <= bus_prev_d;
      wake_q <= wake_d;
      pu_q <= pu_d;
    end
  end
  always_comb begin
    fen_prev_d = fen_s;
    tx_en_d = tx_en_q;
    // latch enable on rising pin edge in normal mode without fault
    if (fault || mode_q != LTX_NORMAL) begin
      tx_en_d = 1'b0;
    end else if (fen_s && !fen_prev_q) begin
      tx_en_d = 1'b1;
    end
    rx_d = bus_s;
    bus_drv_d = tx_en_d & ~tx_s & ~fault;
  end
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_en_q <= TX_EN_RST;
      fen_prev_q <= 1'b1;
      rx_q <= 1'b1;
      bus_drv_q <= 1'b0;
    end else begin
      tx_en_q <= tx_en_d;
      fen_prev_q <= fen_prev_d;
      rx_q <= rx_d;
      bus_drv_q <= bus_drv_d;
    end
  end
  assign BUS_OUT = 1'b0;
  assign BUS_OE_OUT = bus_drv_q;
  assign RX_OUT = 1'b0;
  assign RX_OE_OUT = ~rx_q;
  // weak drive: low on fault, high once enabled
  assign FAULT_OR_TX_ENABLE_PIN_OUT = tx_en_q & ~fault;
  assign FAULT_OR_TX_ENABLE_PIN_OE_OUT = fault | tx_en_q;
  assign FAULT_OR_TX_ENABLE_PIN_WEAK_OUT = 1'b1;
  assign BUS_PULLUP_OUT = (mode_q == LTX_NORMAL) ? 1'b1 : ((mode_q == LTX_SLEEP) ? 1'b0 : pu_q);
  assign MODE_OUT = mode_q;
  assign WAKE_OUT = wake_q;

  // rx follows bus one cycle later
  chk_rx_follow: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    RX_OE_OUT == !$past(bus_s)) else $error("rx does not follow bus");
  chk_rx_open: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !RX_OUT && !BUS_OUT) else $error("open-drain output driven high");
  chk_no_tx_unen: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    BUS_OE_OUT |-> $past(tx_en_d)) else $error("bus driven while disabled");
  chk_tx_recess: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    $past(tx_s) |-> !BUS_OE_OUT) else $error("bus driven with tx high");
  chk_fault_low: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    fault |-> FAULT_OR_TX_ENABLE_PIN_OE_OUT && !FAULT_OR_TX_ENABLE_PIN_OUT) else $error("fault not shown");
  chk_en_latch: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (fen_s && !fen_prev_q && !fault && mode_q == LTX_NORMAL) |=> tx_en_q) else $error("enable not latched");
  chk_pin_enabled: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (tx_en_q && !fault) |-> FAULT_OR_TX_ENABLE_PIN_OE_OUT && FAULT_OR_TX_ENABLE_PIN_OUT)
    else $error("enabled pin not high");
  // fault or mode exit clears enable
  chk_en_clear: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (fault || mode_q != LTX_NORMAL) |=> !tx_en_q) else $error("enable kept");
  chk_pu_sleep: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    mode_q == LTX_SLEEP |-> !BUS_PULLUP_OUT) else $error("pull-up on in sleep");
  chk_pu_norm: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    mode_q == LTX_NORMAL |-> BUS_PULLUP_OUT) else $error("pull-up off in normal");
  chk_pu_hold: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    mode_q != LTX_STANDBY |=> pu_q == $past(pu_q)) else $error("pull-up setting changed");
  chk_wake_arm: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    $rose(WAKE_OUT) |-> $past(armed_q, 2)) else $error("wake without long dominant");
  chk_wake_mode: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    WAKE_OUT |-> $past(mode_q) == LTX_SLEEP && mode_q == LTX_STANDBY) else $error("wake outside sleep");
  chk_wake_asleep: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    mode_q != LTX_SLEEP |=> !WAKE_OUT) else $error("wake while awake");
  chk_weak: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    FAULT_OR_TX_ENABLE_PIN_OE_OUT |-> FAULT_OR_TX_ENABLE_PIN_WEAK_OUT) else $error("strong drive");
  cov_wake: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) WAKE_OUT);
  cov_tx: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) BUS_OE_OUT);
  cov_fault: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) tx_en_q ##1 fault);
  cov_enable: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) $rose(tx_en_q));
  cov_sleep: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) mode_q == LTX_SLEEP ##1 mode_q == LTX_STANDBY);
endmodule

// [ltx_host_model.sv]
// host and lin bus model: wire levels of bus, rx and fault/enable pin
`timescale 1ns/1ps
module ltx_host_model (
  input wire logic clk_in,
  input wire logic bus_oe_in,
  input wire logic rx_oe_in,
  input wire logic dev_val_in,
  input wire logic dev_oe_in,
  input wire logic dom_in,
  input wire logic host_oe_in,
  input wire logic host_val_in,
  output logic bus_out,
  output logic rx_out,
  output logic pin_out
);
  logic last_q = 1'b0;
  assign bus_out = ~(bus_oe_in | dom_in);
  // rx pulled up at the host
  assign rx_out = ~rx_oe_in;
  // host drives or listens; no pull-up
  assign pin_out = host_oe_in ? host_val_in : (dev_oe_in ? dev_val_in : ~last_q);
  // released pin shows the inverse of the last driven level
  always @(posedge clk_in) if (host_oe_in || dev_oe_in) last_q <= pin_out;
endmodule

// [ltx_top_tb.sv]
// self-checking testbench for the lin transceiver host interface
`timescale 1ns/1ps
module ltx_top_tb;
  import ltx_pkg::*;
  logic clk = 0, rst_n = 0, tx = 1, flt = 0, ce = 0, slp = 0, pu_en = 1;
  logic dom = 0, h_oe = 1, h_val = 0;
  logic bus_oe, rx_oe, bus_o, rx_o, p_out, p_oe, p_weak, pu, wake, bus, rx, pin;
  ltx_mode_t mode;
  int error_cnt = 0;
  int checks_done = 0;
  ltx_top uut (.CLK_IN(clk), .ARST_N_IN(rst_n), .TX_IN(tx), .BUS_IN(bus), .BUS_OUT(bus_o),
    .BUS_OE_OUT(bus_oe), .RX_OUT(rx_o), .RX_OE_OUT(rx_oe), .FAULT_OR_TX_ENABLE_PIN_IN(pin),
    .FAULT_OR_TX_ENABLE_PIN_OUT(p_out), .FAULT_OR_TX_ENABLE_PIN_OE_OUT(p_oe),
    .FAULT_OR_TX_ENABLE_PIN_WEAK_OUT(p_weak), .BUS_FAULT_IN(flt), .CHIP_ENABLE_IN(ce),
    .SLEEP_REQ_IN(slp), .BUS_PULLUP_ENABLE_IN(pu_en), .BUS_PULLUP_OUT(pu), .MODE_OUT(mode),
    .WAKE_OUT(wake));
  ltx_host_model host (.clk_in(clk), .bus_oe_in(bus_oe), .rx_oe_in(rx_oe), .dev_val_in(p_out),
    .dev_oe_in(p_oe), .dom_in(dom), .host_oe_in(h_oe), .host_val_in(h_val), .bus_out(bus),
    .rx_out(rx), .pin_out(pin));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    check("mode", mode, LTX_STANDBY);
    check("pullup", pu, 1);
    check("wake", wake, 0);
    tx = 0;
    cyc(6);
    check("bus oe", bus_oe, 0);
    tx = 1;
    $display("reset test done");
  endtask
  task automatic t_rx;
    dom = 1;
    cyc(5);
    check("rx oe", rx_oe, 1);
    check("rx level", rx, 0);
    check("rx value", rx_o, 0);
    dom = 0;
    cyc(5);
    check("rx oe", rx_oe, 0);
    $display("rx test done");
  endtask
  task automatic t_tx;
    ce = 1;
    cyc(5);
    check("mode", mode, LTX_NORMAL);
    check("pullup", pu, 1);
    tx = 0;
    cyc(6);
    check("bus oe", bus_oe, 0);
    tx = 1;
    // pulse held until the enable has latched
    h_val = 1;
    cyc(4);
    h_oe = 0;
    cyc(4);
    check("pin oe", p_oe, 1);
    check("pin", pin, 1);
    tx = 0;
    cyc(5);
    check("bus", bus, 0);
    check("bus value", bus_o, 0);
    tx = 1;
    cyc(5);
    check("bus", bus, 1);
    $display("tx test done");
  endtask
  task automatic t_fault;
    flt = 1;
    cyc(5);
    check("pin", pin, 0);
    check("pin oe", p_oe, 1);
    check("weak", p_weak, 1);
    tx = 0;
    cyc(5);
    check("bus oe", bus_oe, 0);
    tx = 1;
    // host overrides the weak low while the fault stands
    h_oe = 1;
    h_val = 1;
    cyc(5);
    check("pin oe", p_oe, 1);
    check("pin value", p_out, 0);
    flt = 0;
    h_val = 0;
    cyc(5);
    check("pin oe", p_oe, 0);
    $display("fault test done");
  endtask
  task automatic t_sleep;
    logic [1:0] n;
    n = 0;
    pu_en = 0;
    ce = 0;
    cyc(6);
    check("pullup", pu, 0);
    slp = 1;
    cyc(6);
    slp = 0;
    check("mode", mode, LTX_SLEEP);
    check("pullup", pu, 0);
    dom = 1;
    cyc(1000);
    dom = 0;
    cyc(10);
    check("mode", mode, LTX_SLEEP);
    // master holds dominant above the minimum
    dom = 1;
    cyc(2600);
    dom = 0;
    repeat (10) begin
      @(negedge clk);
      n = n + wake;
    end
    check("wake pulses", n, 1);
    check("mode", mode, LTX_STANDBY);
    $display("sleep test done");
  endtask
  initial begin
    cyc(10);
    rst_n = 1;
    cyc(3);
    t_reset();
    t_rx();
    t_tx();
    t_fault();
    t_sleep();
    complete_run();
  end
  initial begin
    #800000;
    error_cnt++;
    complete_run();
  end
endmodule
